// >>> design/dss_pkg.sv
package dss_pkg;

  // Parameter numbers used as access addresses.
  localparam logic [15:0] PAR_INT_REF    = 16'h00E4;
  localparam logic [15:0] PAR_REF_PCT    = 16'h00E5;
  localparam logic [15:0] PAR_ACT_FREQ   = 16'h00F1;
  localparam logic [15:0] PAR_DATA_SET   = 16'h00F9;
  localparam logic [15:0] PAR_DIG_IN     = 16'h00FA;
  localparam logic [15:0] PAR_ERR_CODE   = 16'h0104;
  localparam logic [15:0] PAR_WARNINGS   = 16'h010E;
  localparam logic [15:0] PAR_BUS_REF    = 16'h011A;
  localparam logic [15:0] PAR_RAMP_REF   = 16'h011B;
  localparam logic [15:0] PAR_LEAVE_BEH  = 16'h0188;
  localparam logic [15:0] PAR_STATE_WORD = 16'h019B;
  localparam logic [15:0] PAR_RAMP_SEL   = 16'h01B2;
  localparam logic [15:0] PAR_BUS_FREQ   = 16'h01E4;
  localparam logic [15:0] PAR_BUS_PCT    = 16'h020C;

  // Reset and legal values.
  localparam logic [1:0]  LEAVE_COAST    = 2'h0;
  localparam logic [1:0]  LEAVE_DCBRAKE  = 2'h1;
  localparam logic [1:0]  LEAVE_RAMP     = 2'h2;
  localparam logic [1:0]  SEL_INTERNAL   = 2'h1;
  localparam logic [1:0]  SEL_BUS        = 2'h2;
  localparam logic [1:0]  SEL_SUM        = 2'h3;

  // Statusword images.
  localparam logic [15:0] SW_DISABLED    = 16'h0040;
  localparam logic [15:0] SW_SWITCHED_ON = 16'h0023;
  localparam logic [15:0] SW_OP_ENABLED  = 16'h0027;
  localparam logic [15:0] SW_QUICK_STOP  = 16'h0007;

  // Timing: timers and ramp steps advance once per 0.1 s tick.
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          TICK_TIME_NS   = 100_000_000;
  localparam int          TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam logic [19:0] RATE_DIV       = 20'h0000A;
  localparam logic [31:0] THR_SCALE      = 32'h000003E8;

  typedef enum logic [2:0] {
    M_DISABLED, M_SWON, M_OPEN, M_RAMPDN, M_BRAKE, M_QSTOP, M_HOLD
  } dss_mode_t;

  typedef struct packed {
    logic [19:0] qsRateCw;
    logic [19:0] qsRateAcw;
    logic [19:0] rampRate;
    logic [9:0]  thrPermille;
    logic [11:0] holdTime;
    logic [11:0] brakeTime;
    logic [15:0] fMax;
    logic [15:0] fMin;
  } dss_stop_cfg_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [15:0] num;
    logic [15:0] wdata;
  } dss_par_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } dss_par_rsp_t;

  typedef struct packed {
    dss_mode_t          mode;
    logic               holdQs;
    logic [31:0]        tickCnt;
    logic [15:0]        timer;
    logic [1:0]         leaveSel;
    logic [3:0][1:0]    rampSel;
    logic signed [15:0] busFreq;
    logic [15:0]        busPct;
    logic               busNeg;
    logic signed [15:0] outFreq;
    logic               drvEn;
    logic               dcInj;
    logic [15:0]        stWord;
    dss_par_rsp_t       rsp;
  } dss_state_t;

endpackage : dss_pkg

// >>> design/dss_stop_ctrl.sv
`timescale 1ns/1ps
module dss_stop_ctrl
  import dss_pkg::*;
#(
  parameter int TICK_CYC = dss_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  // Parameter access from the fieldbus interpreter.
  input  wire dss_pkg::dss_par_req_t parReq,
  output dss_pkg::dss_par_rsp_t      parRsp,
  // Controlword strobe.
  input  wire logic                 cwStrobe,
  input  wire logic [15:0]          cwWord,
  // Configuration of the drive.
  input  wire logic                 cfgMotion,
  input  wire logic                 cfgVf,
  input  wire logic                 cfgTorque,
  input  wire logic                 cfgChange,
  input  wire logic [1:0]           activeSet,
  input  wire dss_pkg::dss_stop_cfg_t stopCfg,
  // Local values for read-back and summing.
  input  wire logic signed [15:0]   internalRef,
  input  wire logic [15:0]          localPct,
  input  wire logic signed [15:0]   encoderFreq,
  input  wire logic [15:0]          digInputs,
  input  wire logic [15:0]          errorCode,
  input  wire logic [15:0]          warnings,
  // Power stage.
  output logic signed [15:0]        outFreq,
  output logic                      drvEn,
  output logic                      dcInj,
  output logic [15:0]               stateWord
);
  import dss_pkg::*;

  dss_state_t         stReg;
  dss_state_t         stNext;
  logic               tick;
  logic [1:0]         selNow;
  logic signed [15:0] busLine;
  logic signed [15:0] rampRef;
  logic signed [15:0] actFreq;
  logic [15:0]        absOut;
  logic               belowThr;
  logic [19:0]        qsRate;
  logic               accept;

  function automatic logic is_enable_op(input logic [15:0] cw);
    return cw[3:0] == 4'hF;
  endfunction : is_enable_op

  function automatic logic is_disable_op(input logic [15:0] cw);
    return cw[3:0] == 4'h7;
  endfunction : is_disable_op

  function automatic logic is_quick_stop(input logic [15:0] cw);
    return cw[2:1] == 2'b01;
  endfunction : is_quick_stop

  // One ramp step of rate/10 per 0.1 s tick, never overshooting the target.
  function automatic logic signed [15:0] step_to(input logic signed [15:0] cur,
                                                 input logic signed [15:0] tgt,
                                                 input logic [19:0]        rate);
    int d;
    int s;
    d = int'(tgt) - int'(cur);
    s = int'(rate / RATE_DIV);
    if (s == 0) s = 1;
    if (d > s) return 16'(int'(cur) + s);
    if (d < -s) return 16'(int'(cur) - s);
    return tgt;
  endfunction : step_to

  function automatic logic [15:0] status_of(input dss_mode_t m, input logic qs);
    unique case (m)
      M_DISABLED: return SW_DISABLED;
      M_SWON:     return SW_SWITCHED_ON;
      M_QSTOP:    return SW_QUICK_STOP;
      M_HOLD:     return qs ? SW_QUICK_STOP : SW_OP_ENABLED;
      M_OPEN, M_RAMPDN, M_BRAKE: return SW_OP_ENABLED;
    endcase
  endfunction : status_of

  always_comb begin
    tick   = stReg.tickCnt == 32'(TICK_CYC - 1);
    selNow = stReg.rampSel[activeSet];
    absOut = stReg.outFreq[15] ? 16'(-stReg.outFreq) : stReg.outFreq;
    // Products are 32 bits wide so the full fmax range cannot overflow.
    belowThr = (32'(absOut) * THR_SCALE) <
               (32'(stopCfg.thrPermille) * 32'(stopCfg.fMax));
    qsRate = stReg.outFreq[15] ? stopCfg.qsRateAcw : stopCfg.qsRateCw;
    actFreq = cfgMotion ? encoderFreq : stReg.outFreq;
    busLine = stReg.busFreq;
    if (selNow == SEL_BUS) begin
      if ((stReg.busFreq[15] ? 16'(-stReg.busFreq) : stReg.busFreq) < stopCfg.fMin) begin
        // A fresh zero keeps the last non-zero sign; reset leaves it positive.
        if (stReg.busFreq != 16'h0000) busLine = stReg.busFreq[15] ? 16'(-stopCfg.fMin) : stopCfg.fMin;
        else busLine = stReg.busNeg ? 16'(-stopCfg.fMin) : stopCfg.fMin;
      end
    end
    if (cfgMotion) rampRef = stReg.busFreq;
    else begin
      unique case (selNow)
        SEL_INTERNAL: rampRef = internalRef;
        SEL_BUS:      rampRef = busLine;
        default:      rampRef = 16'(internalRef + stReg.busFreq);
      endcase
    end
  end

  always_comb begin
    stNext         = stReg;
    stNext.rsp.ack = 1'b0;
    stNext.rsp.err = 1'b0;
    stNext.tickCnt = tick ? 32'h00000000 : stReg.tickCnt + 32'h00000001;
    // Controlwords arriving while DC braking runs are dropped, not queued.
    accept = cwStrobe && stReg.mode != M_BRAKE;

    unique case (stReg.mode)
      M_DISABLED: begin
        if (accept && cwWord[2:0] == 3'h7) stNext.mode = M_SWON;
      end
      M_SWON: begin
        if (accept && is_enable_op(cwWord)) begin
          stNext.mode  = M_OPEN;
          stNext.drvEn = 1'b1;
        end
      end
      M_OPEN: begin
        if (tick) stNext.outFreq = step_to(stReg.outFreq, rampRef, stopCfg.rampRate);
        if (accept && is_disable_op(cwWord)) begin
          if (cfgMotion || stReg.leaveSel == LEAVE_COAST) begin
            stNext.mode    = M_SWON;
            stNext.drvEn   = 1'b0;
            stNext.outFreq = 16'h0000;
          end else if (stReg.leaveSel == LEAVE_DCBRAKE) begin
            stNext.mode    = M_BRAKE;
            stNext.dcInj   = 1'b1;
            stNext.outFreq = 16'h0000;
            stNext.timer   = 16'h0000;
          end else begin
            stNext.mode = M_RAMPDN;
          end
        end
      end
      M_RAMPDN: begin
        if (tick) stNext.outFreq = step_to(stReg.outFreq, 16'h0000, stopCfg.rampRate);
        if (accept && is_enable_op(cwWord)) stNext.mode = M_OPEN;
        else if (belowThr) begin
          stNext.mode   = M_HOLD;
          stNext.holdQs = 1'b0;
          stNext.dcInj  = 1'b1;
          stNext.timer  = 16'h0000;
        end
      end
      M_QSTOP: begin
        if (tick) stNext.outFreq = step_to(stReg.outFreq, 16'h0000, qsRate);
        if (cfgMotion && stReg.outFreq == 16'h0000) begin
          stNext.mode  = M_DISABLED;
          stNext.drvEn = 1'b0;
        end else if (!cfgMotion && belowThr) begin
          stNext.mode   = M_HOLD;
          stNext.holdQs = 1'b1;
          stNext.dcInj  = 1'b1;
          stNext.timer  = 16'h0000;
        end
      end
      M_HOLD: begin
        // Injection goes on once speed falls below the threshold; the output keeps ramping to zero until the holding time ends.
        if (tick) begin
          stNext.outFreq = step_to(stReg.outFreq, 16'h0000, stReg.holdQs ? qsRate : stopCfg.rampRate);
          stNext.timer   = stReg.timer + 16'h0001;
        end
        if (stReg.timer >= {4'h0, stopCfg.holdTime}) begin
          stNext.mode    = stReg.holdQs ? M_DISABLED : M_SWON;
          stNext.dcInj   = 1'b0;
          stNext.drvEn   = 1'b0;
          stNext.outFreq = 16'h0000;
        end
      end
      M_BRAKE: begin
        if (tick) stNext.timer = stReg.timer + 16'h0001;
        if (stReg.timer >= {4'h0, stopCfg.brakeTime}) begin
          stNext.mode  = M_SWON;
          stNext.dcInj = 1'b0;
          stNext.drvEn = 1'b0;
        end
      end
    endcase

    // Quick stop and disable voltage override the per-state handling.
    if (accept && stReg.mode inside {M_OPEN, M_RAMPDN} && is_quick_stop(cwWord)) begin
      stNext.mode = M_QSTOP;
    end
    if (accept && !cwWord[1] && stReg.mode != M_DISABLED) begin
      stNext.mode    = M_DISABLED;
      stNext.drvEn   = 1'b0;
      stNext.dcInj   = 1'b0;
      stNext.outFreq = 16'h0000;
    end

    if (cfgChange) begin
      if (cfgTorque) stNext.leaveSel = LEAVE_COAST;
      else if (stReg.leaveSel == LEAVE_DCBRAKE && !cfgVf) stNext.leaveSel = LEAVE_RAMP;
    end

    if (parReq.req) begin
      stNext.rsp.ack   = 1'b1;
      stNext.rsp.rdata = 16'h0000;
      if (parReq.write) begin
        unique case (parReq.num)
          PAR_LEAVE_BEH: begin
            if (parReq.wdata > 16'(LEAVE_RAMP) || (parReq.wdata == 16'(LEAVE_DCBRAKE) && !cfgVf))
              stNext.rsp.err = 1'b1;
            else stNext.leaveSel = parReq.wdata[1:0];
          end
          PAR_RAMP_SEL: begin
            if (parReq.wdata < 16'(SEL_INTERNAL) || parReq.wdata > 16'(SEL_SUM)) stNext.rsp.err = 1'b1;
            else stNext.rampSel[activeSet] = parReq.wdata[1:0];
          end
          PAR_BUS_FREQ: begin
            stNext.busFreq = parReq.wdata;
            if (parReq.wdata != 16'h0000) stNext.busNeg = parReq.wdata[15];
          end
          PAR_BUS_PCT: stNext.busPct = parReq.wdata;
          default:     stNext.rsp.err = 1'b1;
        endcase
      end else begin
        unique case (parReq.num)
          PAR_INT_REF:    stNext.rsp.rdata = internalRef;
          PAR_REF_PCT:    stNext.rsp.rdata = localPct + stReg.busPct;
          PAR_ACT_FREQ:   stNext.rsp.rdata = actFreq;
          PAR_DATA_SET:   stNext.rsp.rdata = {14'h0000, activeSet} + 16'h0001;
          PAR_DIG_IN:     stNext.rsp.rdata = digInputs;
          PAR_ERR_CODE:   stNext.rsp.rdata = errorCode;
          PAR_WARNINGS:   stNext.rsp.rdata = warnings;
          PAR_BUS_REF:    stNext.rsp.rdata = busLine;
          PAR_RAMP_REF:   stNext.rsp.rdata = rampRef;
          PAR_LEAVE_BEH:  stNext.rsp.rdata = {14'h0000, stReg.leaveSel};
          PAR_STATE_WORD: stNext.rsp.rdata = status_of(stReg.mode, stReg.holdQs);
          PAR_RAMP_SEL:   stNext.rsp.rdata = {14'h0000, selNow};
          default:        stNext.rsp.err   = 1'b1;
        endcase
      end
    end
    // Registered so the status word reaches the pins straight from a flip-flop, free of decode glitches.
    stNext.stWord = status_of(stNext.mode, stNext.holdQs);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stReg          <= '0;
      stReg.mode     <= M_DISABLED;
      stReg.leaveSel <= LEAVE_RAMP;
      stReg.rampSel  <= {4{SEL_SUM}};
      stReg.stWord   <= SW_DISABLED;
    end else begin
      stReg <= stNext;
    end
  end

  always_comb begin
    parRsp    = stReg.rsp;
    outFreq   = stReg.outFreq;
    drvEn     = stReg.drvEn;
    dcInj     = stReg.dcInj;
    stateWord = stReg.stWord;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  leave_legal_a: assert property (stReg.leaveSel != 2'h3)
    else $error("Leave behaviour holds an illegal value.");
  coast_now_a: assert property (stReg.mode == M_OPEN && accept && is_disable_op(cwWord) && cwWord[1]
                                && !cfgMotion && stReg.leaveSel == LEAVE_COAST
                                |=> stReg.mode == M_SWON && !drvEn && outFreq == 16'h0000)
    else $error("Coast exit did not reach switched-on at once.");
  brake_exit_a: assert property (stReg.mode == M_BRAKE && stNext.mode == M_SWON
                                 |-> stReg.timer >= {4'h0, stopCfg.brakeTime} && !stNext.dcInj)
    else $error("DC brake ended before its braking time.");
  brake_ignore_a: assert property (stReg.mode == M_BRAKE && cwStrobe && stReg.timer < {4'h0, stopCfg.brakeTime}
                                   |=> stReg.mode == M_BRAKE && dcInj)
    else $error("Controlword acted during DC braking.");
  ramp_back_a: assert property (stReg.mode == M_RAMPDN && cwStrobe && cwWord[3:0] == 4'hF
                                |=> stReg.mode == M_OPEN ##1 stReg.mode != M_SWON)
    else $error("Re-enable during ramp-down did not return to operation.");
  hold_time_a: assert property (stReg.mode == M_HOLD && stNext.mode == M_SWON
                                |-> stReg.timer >= {4'h0, stopCfg.holdTime})
    else $error("Left the hold before the holding time.");
  dc_in_hold_a: assert property (stReg.mode == M_HOLD |-> dcInj)
    else $error("No DC injection during hold.");
  hold_entry_a: assert property ($rose(stReg.mode == M_HOLD) |-> stReg.timer == 16'h0000)
    else $error("Hold timer did not start from zero.");
  qs_rate_a: assert property (stReg.mode == M_QSTOP && tick && !stReg.outFreq[15]
                              && int'(stReg.outFreq) > int'(stopCfg.qsRateCw / RATE_DIV)
                              && stopCfg.qsRateCw >= RATE_DIV && !cwStrobe && !cfgMotion && !belowThr
                              |=> int'(outFreq)
                                  == int'($past(outFreq)) - int'($past(stopCfg.qsRateCw) / RATE_DIV))
    else $error("Quick stop did not use the clockwise emergency rate.");
  read_refuse_a: assert property (parReq.req && !parReq.write
                                  && (parReq.num == PAR_BUS_FREQ || parReq.num == PAR_BUS_PCT)
                                  |=> parRsp.ack && parRsp.err && parRsp.rdata == 16'h0000)
    else $error("Write-only reference was readable.");
  dc_reject_a: assert property (parReq.req && parReq.write && parReq.num == PAR_LEAVE_BEH
                                && parReq.wdata == 16'h0001 && !cfgVf && !cfgChange
                                |=> parRsp.err && stReg.leaveSel == $past(stReg.leaveSel))
    else $error("DC brake setting accepted without v/f characteristic.");
  qs_acw_rate_a: assert property (stReg.mode == M_QSTOP && tick && stReg.outFreq[15]
                                  && -int'(stReg.outFreq) > int'(stopCfg.qsRateAcw / RATE_DIV)
                                  && stopCfg.qsRateAcw >= RATE_DIV && !cwStrobe && !cfgMotion
                                  |=> int'(outFreq)
                                      == int'($past(outFreq)) + int'($past(stopCfg.qsRateAcw) / RATE_DIV))
    else $error("Quick stop did not use the anticlockwise emergency rate.");
  qs_entry_a: assert property (accept && stReg.mode inside {M_OPEN, M_RAMPDN} && is_quick_stop(cwWord)
                               |=> stReg.mode == M_QSTOP)
    else $error("Quick stop command did not start the emergency ramp.");
  brake_entry_a: assert property (stReg.mode == M_OPEN && accept && is_disable_op(cwWord) && !cfgMotion
                                  && stReg.leaveSel == LEAVE_DCBRAKE
                                  |=> stReg.mode == M_BRAKE && dcInj && outFreq == 16'h0000)
    else $error("DC brake exit did not start braking.");
  ramp_entry_a: assert property (stReg.mode == M_OPEN && accept && is_disable_op(cwWord) && !cfgMotion
                                 && stReg.leaveSel == LEAVE_RAMP |=> stReg.mode == M_RAMPDN && drvEn)
    else $error("Ramp exit did not start the normal stop ramp.");
  hold_stay_a: assert property (stReg.mode == M_HOLD && stReg.timer < {4'h0, stopCfg.holdTime}
                                && !(accept && !cwWord[1]) |=> stReg.mode == M_HOLD && dcInj)
    else $error("Hold ended before the holding time.");
  torque_default_a: assert property (cfgChange && cfgTorque
                                     && !(parReq.req && parReq.write && parReq.num == PAR_LEAVE_BEH)
                                     |=> stReg.leaveSel == LEAVE_COAST)
    else $error("Torque configuration did not default to coasting.");
  idle_power_a: assert property (stReg.mode inside {M_DISABLED, M_SWON}
                                 |-> !drvEn && !dcInj && outFreq == 16'h0000)
    else $error("Power stage active while switched on or disabled.");
  bus_clamp_a: assert property (!cfgMotion && selNow == SEL_BUS
                                |-> (rampRef[15] ? -int'(rampRef) : int'(rampRef)) >= int'(stopCfg.fMin))
    else $error("Bus-only reference fell below minimum frequency.");

  cov_coast_c: cover property (stReg.mode == M_OPEN ##1 stReg.mode == M_SWON);
  cov_brake_c: cover property (stReg.mode == M_BRAKE ##1 stReg.mode == M_SWON);
  cov_hold_c:  cover property (stReg.mode == M_HOLD && !stReg.holdQs ##1 stReg.mode == M_SWON);
  cov_qs_c:    cover property (stReg.mode == M_HOLD && stReg.holdQs ##1 stReg.mode == M_DISABLED);
  cov_back_c:  cover property (stReg.mode == M_RAMPDN ##1 stReg.mode == M_OPEN);

endmodule : dss_stop_ctrl

// >>> verification/dss_plc_model.sv
`timescale 1ns/1ps
module dss_plc_model
  import dss_pkg::*;
(
  // Clock.
  input  wire logic                  ref_clk,
  // Parameter channel.
  output dss_pkg::dss_par_req_t      parReq,
  input  wire dss_pkg::dss_par_rsp_t parRsp,
  // Controlword channel.
  output logic                       cwStrobe,
  output logic [15:0]                cwWord
);
  import dss_pkg::*;

  initial begin
    parReq   = '0;
    cwStrobe = 1'b0;
    cwWord   = 16'h0000;
  end

  // One access per call; a released data bus shows the inverse so stale values cannot pass.
  task automatic access(input logic wr, input logic [15:0] num, input logic [15:0] wd, output dss_par_rsp_t rsp);
    int n;
    n = 0;
    @(negedge ref_clk);
    parReq = '{req: 1'b1, write: wr, num: num, wdata: wd};
    @(negedge ref_clk);
    parReq.req   = 1'b0;
    parReq.wdata = ~wd;
    while (parRsp.ack !== 1'b1 && n < 3) begin
      @(negedge ref_clk);
      n++;
    end
    rsp = parRsp;
  endtask : access

  // A controlword write; during braking the caller expects it to have no effect.
  task automatic cw(input logic [15:0] w);
    @(negedge ref_clk);
    cwWord   = w;
    cwStrobe = 1'b1;
    @(negedge ref_clk);
    cwStrobe = 1'b0;
    cwWord   = ~w;
    @(negedge ref_clk);
  endtask : cw
endmodule : dss_plc_model

// >>> verification/test_drive_stop_and_setpoint_ctrl.sv
`timescale 1ns/1ps
module test_drive_stop_and_setpoint_ctrl;
  import dss_pkg::*;

  logic                  ref_clk;
  logic                  nrst;
  dss_par_req_t          parReq;
  dss_par_rsp_t          parRsp;
  logic                  cwStrobe;
  logic [15:0]           cwWord;
  logic                  cfgMotion, cfgVf, cfgTorque, cfgChange;
  logic [1:0]            activeSet;
  dss_stop_cfg_t         stopCfg;
  logic signed [15:0]    internalRef, encoderFreq, outFreq;
  logic [15:0]           localPct, digInputs, errorCode, warnings, stateWord;
  logic                  drvEn, dcInj;
  int                    errTotal, cmpCount, n;

  dss_stop_ctrl #(.TICK_CYC(10)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .parReq(parReq), .parRsp(parRsp),
    .cwStrobe(cwStrobe), .cwWord(cwWord), .cfgMotion(cfgMotion), .cfgVf(cfgVf), .cfgTorque(cfgTorque),
    .cfgChange(cfgChange), .activeSet(activeSet), .stopCfg(stopCfg), .internalRef(internalRef),
    .localPct(localPct), .encoderFreq(encoderFreq), .digInputs(digInputs), .errorCode(errorCode),
    .warnings(warnings), .outFreq(outFreq), .drvEn(drvEn), .dcInj(dcInj), .stateWord(stateWord));

  dss_plc_model u_plc (.ref_clk(ref_clk), .parReq(parReq), .parRsp(parRsp), .cwStrobe(cwStrobe), .cwWord(cwWord));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("errors %0d comparisons %0d", errTotal, cmpCount);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [15:0] num, input logic [15:0] exp, input logic experr);
    dss_par_rsp_t r;
    u_plc.access(1'b0, num, 16'h0000, r);
    chk("read status", {14'h0000, experr, 1'b1}, {14'h0000, r.err, r.ack});
    if (!experr) chk("read data", exp, r.rdata);
  endtask : rd

  task automatic wr(input logic [15:0] num, input logic [15:0] val, input logic experr);
    dss_par_rsp_t r;
    u_plc.access(1'b1, num, val, r);
    chk("write status", {14'h0000, experr, 1'b1}, {14'h0000, r.err, r.ack});
  endtask : wr

  // Waiting is bounded so a stuck drive ends the wait instead of the run.
  task automatic waitFor(input int s, input logic [15:0] e, input int lim);
    n = 0;
    while ((s == 0 ? stateWord : s == 1 ? outFreq : {15'h0000, dcInj}) !== e && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : waitFor

  initial begin
    #400000;
    errTotal++;
    conclude();
  end

  initial begin
    nrst = 1'b0; cfgMotion = 1'b0; cfgVf = 1'b0; cfgTorque = 1'b0; cfgChange = 1'b0; activeSet = 2'h0;
    stopCfg = '{qsRateCw: 20'h00064, qsRateAcw: 20'h007D0, rampRate: 20'h003E8, thrPermille: 10'h064,
                holdTime: 12'h003, brakeTime: 12'h003, fMax: 16'h03E8, fMin: 16'h0064};
    internalRef = 16'sh012C; encoderFreq = 16'sh0123; localPct = 16'h0064;
    digInputs = 16'h00A5; errorCode = 16'h0000; warnings = 16'h0000;
    errTotal = 0; cmpCount = 0;
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    chk("state after reset", SW_DISABLED, stateWord);
    rd(PAR_LEAVE_BEH, 16'h0002, 1'b0);
    rd(PAR_RAMP_SEL, 16'h0003, 1'b0);
    rd(PAR_BUS_FREQ, 16'h0000, 1'b1);
    rd(PAR_BUS_PCT, 16'h0000, 1'b1);
    wr(PAR_LEAVE_BEH, 16'h0003, 1'b1);
    wr(PAR_LEAVE_BEH, 16'h0001, 1'b1);
    wr(PAR_RAMP_SEL, 16'h0002, 1'b0);
    rd(PAR_BUS_REF, 16'h0064, 1'b0);
    wr(PAR_BUS_FREQ, 16'hFD44, 1'b0);
    rd(PAR_BUS_REF, 16'hFD44, 1'b0);
    wr(PAR_BUS_FREQ, 16'h0000, 1'b0);
    rd(PAR_BUS_REF, 16'hFF9C, 1'b0);
    wr(PAR_BUS_FREQ, 16'h000A, 1'b0);
    rd(PAR_BUS_REF, 16'h0064, 1'b0);
    stopCfg.fMin = 16'h00C8;
    rd(PAR_BUS_REF, 16'h00C8, 1'b0);
    wr(PAR_RAMP_SEL, 16'h0003, 1'b0);
    wr(PAR_BUS_FREQ, 16'hFE0C, 1'b0);
    rd(PAR_RAMP_REF, 16'hFF38, 1'b0);
    wr(PAR_RAMP_SEL, 16'h0001, 1'b0);
    rd(PAR_RAMP_REF, 16'h012C, 1'b0);
    rd(PAR_INT_REF, 16'h012C, 1'b0);
    wr(PAR_BUS_PCT, 16'h0032, 1'b0);
    rd(PAR_REF_PCT, 16'h0096, 1'b0);
    localPct = 16'h00C8;
    rd(PAR_REF_PCT, 16'h00FA, 1'b0);
    rd(PAR_DIG_IN, 16'h00A5, 1'b0);
    rd(PAR_STATE_WORD, SW_DISABLED, 1'b0);
    digInputs = 16'h005A;
    errorCode = 16'h0105;
    warnings = 16'h0081;
    activeSet = 2'h1;
    rd(PAR_DIG_IN, 16'h005A, 1'b0);
    rd(PAR_ERR_CODE, 16'h0105, 1'b0);
    rd(PAR_WARNINGS, 16'h0081, 1'b0);
    rd(PAR_DATA_SET, 16'h0002, 1'b0);
    rd(PAR_RAMP_SEL, 16'h0003, 1'b0);
    activeSet = 2'h0;
    cfgMotion = 1'b1;
    rd(PAR_ACT_FREQ, 16'h0123, 1'b0);
    encoderFreq = 16'shFF38;
    rd(PAR_ACT_FREQ, 16'hFF38, 1'b0);
    rd(PAR_RAMP_REF, 16'hFE0C, 1'b0);
    cfgMotion = 1'b0;
    rd(PAR_ACT_FREQ, 16'h0000, 1'b0);
    cfgTorque = 1'b1;
    cfgChange = 1'b1;
    @(negedge ref_clk);
    cfgChange = 1'b0;
    cfgTorque = 1'b0;
    rd(PAR_LEAVE_BEH, 16'h0000, 1'b0);
    internalRef = 16'sh01F4;
    u_plc.cw(16'h0007);
    u_plc.cw(16'h000F);
    chk("enabled", SW_OP_ENABLED, stateWord);
    u_plc.cw(16'h0007);
    chk("coast state", SW_SWITCHED_ON, stateWord);
    chk("coast power", 16'h0000, {15'h0000, drvEn});
    cfgVf = 1'b1;
    wr(PAR_LEAVE_BEH, 16'h0001, 1'b0);
    stopCfg.brakeTime = 12'h004;
    u_plc.cw(16'h000F);
    u_plc.cw(16'h0007);
    chk("brake active", 16'h0001, {15'h0000, dcInj});
    u_plc.cw(16'h0000);
    chk("brake ignores cw", SW_OP_ENABLED, stateWord);
    waitFor(0, SW_SWITCHED_ON, 80);
    chk("brake end", SW_SWITCHED_ON, stateWord);
    chk("brake length", 16'h0001, {15'h0000, n >= 27 && n <= 38});
    wr(PAR_LEAVE_BEH, 16'h0002, 1'b0);
    u_plc.cw(16'h000F);
    waitFor(1, 16'h01F4, 150);
    u_plc.cw(16'h0007);
    repeat (12) @(negedge ref_clk);
    u_plc.cw(16'h000F);
    waitFor(1, 16'h01F4, 150);
    chk("run back up", 16'h01F4, outFreq);
    chk("still enabled", SW_OP_ENABLED, stateWord);
    u_plc.cw(16'h0007);
    waitFor(2, 16'h0001, 150);
    waitFor(0, SW_SWITCHED_ON, 80);
    chk("ramp exit", SW_SWITCHED_ON, stateWord);
    chk("hold length", 16'h0001, {15'h0000, n >= 25});
    stopCfg.holdTime = 12'h002;
    internalRef = 16'shFE0C;
    u_plc.cw(16'h000F);
    waitFor(1, 16'hFE0C, 150);
    u_plc.cw(16'h000B);
    waitFor(2, 16'h0001, 45);
    chk("reverse stop rate", 16'h0001, {15'h0000, dcInj});
    chk("quick stop hold", SW_QUICK_STOP, stateWord);
    waitFor(0, SW_DISABLED, 80);
    chk("quick stop end", SW_DISABLED, stateWord);
    chk("quick stop hold length", 16'h0001, {15'h0000, n >= 18 && n <= 22});
    internalRef = 16'sh01F4;
    u_plc.cw(16'h0007);
    u_plc.cw(16'h000F);
    waitFor(1, 16'h01F4, 150);
    u_plc.cw(16'h000B);
    waitFor(2, 16'h0001, 45);
    chk("forward stop rate", 16'h0000, {15'h0000, dcInj});
    waitFor(2, 16'h0001, 500);
    waitFor(0, SW_DISABLED, 80);
    chk("forward stop end", SW_DISABLED, stateWord);
    conclude();
  end
endmodule : test_drive_stop_and_setpoint_ctrl
